// ==== hdl/scd_device.sv ====
// Purpose: samples both switches after power-up, decodes address and overload setup
// Assumes: resetn is the power-on reset; switch and monitor inputs synchronous to sys_clk
// Notes: switches are read once, in the first cycle after reset release
//        a switch moved while powered is ignored until the next reset
//        reserved config bit 8 selects no limit of its own
//        torque cut and warning follow the overload input by one cycle
`timescale 1ns/1ps
module scd_device (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// switches and overload monitor
	input wire logic [7:0] node_address_switch,
	input wire logic [7:0] overload_config_switch,
	input wire logic overload_detected,
	// drive side outputs
	output logic torque_off_signal,
	output logic overload_warning_output,
	output logic [4:0] current_limit_a,
	// fieldbus link
	scd_link_if.device link
);

	// ----------------------------------------------------------------
	// limit decode
	// ----------------------------------------------------------------
	function automatic logic [4:0] decode_limit(input logic [7:0] cfg);
		logic [4:0] lim;
		lim = scd_pkg::LIM_DEFAULT_A;
		// lowest selected limit wins; reserved bit 8 contributes nothing
		if (cfg[scd_pkg::CFG_B2]) begin
			lim = scd_pkg::LIM_B2_A;
		end else if (cfg[scd_pkg::CFG_B3]) begin
			lim = scd_pkg::LIM_B3_A;
		end else if (cfg[scd_pkg::CFG_B4]) begin
			lim = scd_pkg::LIM_B4_A;
		end else if (cfg[scd_pkg::CFG_B5]) begin
			lim = scd_pkg::LIM_B5_A;
		end else if (cfg[scd_pkg::CFG_B6]) begin
			lim = scd_pkg::LIM_B6_A;
		end else if (cfg[scd_pkg::CFG_B7]) begin
			lim = scd_pkg::LIM_B7_A;
		end
		return lim;
	endfunction

	// fixed address when the latched switch is nonzero
	function automatic logic addr_fixed(input logic [7:0] sw);
		return sw != scd_pkg::ADDR_AUTO;
	endfunction

	// torque cut only when config bit 1 asks for it
	function automatic logic torque_cut(input logic ovl, input logic [7:0] cfg);
		return ovl && cfg[scd_pkg::CFG_TORQUE_BIT];
	endfunction

	// parameter access is open in pre-operational and operational
	function automatic logic service_open(input scd_pkg::scd_state_e st);
		return (st == scd_pkg::SCD_PREOP) || (st == scd_pkg::SCD_OP);
	endfunction

	// ----------------------------------------------------------------
	// power-up sampling
	// ----------------------------------------------------------------
	logic sampled;
	logic [7:0] addr_sw;
	logic [7:0] cfg_sw;
	logic next_sampled;
	logic [7:0] next_addr_sw;
	logic [7:0] next_cfg_sw;

	always_comb begin
		// the latch closes after one cycle; only reset reopens it
		next_sampled = 1'b1;
		next_addr_sw = addr_sw;
		next_cfg_sw = cfg_sw;
		if (!sampled) begin
			next_addr_sw = node_address_switch;
			next_cfg_sw = overload_config_switch;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sampled <= 1'b0;
			addr_sw <= 8'h00;
			cfg_sw <= 8'h00;
		end else begin
			sampled <= next_sampled;
			addr_sw <= next_addr_sw;
			cfg_sw <= next_cfg_sw;
		end
	end

	// ----------------------------------------------------------------
	// node address
	// ----------------------------------------------------------------
	logic [7:0] node_addr;
	logic addr_valid;
	logic [7:0] next_node_addr;
	logic next_addr_valid;
	logic fixed_addr;

	assign fixed_addr = addr_fixed(addr_sw);

	always_comb begin
		next_node_addr = node_addr;
		next_addr_valid = addr_valid;
		if (sampled) begin
			// a fixed address ignores every assignment from the master
			if (fixed_addr) begin
				next_node_addr = addr_sw;
				next_addr_valid = 1'b1;
			end else if (link.assign_valid && link.assign_addr != scd_pkg::ADDR_AUTO) begin
				next_node_addr = link.assign_addr;
				next_addr_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			node_addr <= 8'h00;
			addr_valid <= 1'b0;
		end else begin
			node_addr <= next_node_addr;
			addr_valid <= next_addr_valid;
		end
	end

	// ----------------------------------------------------------------
	// slave state
	// ----------------------------------------------------------------
	scd_pkg::scd_state_e state;
	scd_pkg::scd_state_e next_state;

	always_comb begin
		next_state = state;
		case (state)
			scd_pkg::SCD_INIT: begin
				if (addr_valid) begin
					next_state = scd_pkg::SCD_PREOP;
				end
			end
			scd_pkg::SCD_PREOP: begin
				if (link.op_req && !link.config_error) begin
					next_state = scd_pkg::SCD_OP;
				end
			end
			scd_pkg::SCD_OP: begin
				if (link.config_error || !link.op_req) begin
					next_state = scd_pkg::SCD_PREOP;
				end
			end
			// the unused code falls back to init
			default: begin
				next_state = scd_pkg::SCD_INIT;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= scd_pkg::SCD_INIT;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// overload reaction
	// ----------------------------------------------------------------
	logic next_torque_off;
	logic next_warn;
	logic [4:0] next_limit;

	always_comb begin
		next_warn = 1'b0;
		next_torque_off = 1'b0;
		next_limit = current_limit_a;
		if (sampled) begin
			// limit held at its reset value until the latch has closed
			next_limit = decode_limit(cfg_sw);
			// the warning does not depend on bit 1
			next_warn = overload_detected;
			// bit 1 clear leaves only the warning actions
			next_torque_off = torque_cut(overload_detected, cfg_sw);
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			torque_off_signal <= 1'b0;
			overload_warning_output <= 1'b0;
			current_limit_a <= scd_pkg::LIM_DEFAULT_A;
		end else begin
			torque_off_signal <= next_torque_off;
			overload_warning_output <= next_warn;
			current_limit_a <= next_limit;
		end
	end

	// ----------------------------------------------------------------
	// link outputs
	// ----------------------------------------------------------------
	assign link.node_addr = node_addr;
	assign link.addr_valid = addr_valid;
	assign link.slave_state = state;
	// service channel stays usable after a configuration mismatch
	assign link.service_ready = service_open(state);
	assign link.overload_warn = overload_warning_output;

endmodule

// ==== include/scd_pkg.sv ====
// Purpose: shared constants for the switch configuration decoder and its bus master end
// Assumes: one clock, sys_clk at 100 MHz, asynchronous active-low reset
// Notes: register map belongs to the master end, reached over APB
//
// Summary of operation
// - address switch sampled only at power-up
// - zero address switch: master assigns node address
// - nonzero switch value is fixed node address
// - master assigns address equal to chain position
// - master talks only to addressed slaves
// - master reassigns addresses after topology change
// - master reports 2727 info 2 on mismatch
// - mismatch puts slave in pre-operational, service open
// - config switch latched only at power-up
// - bit 1 set: overload forces torque off
// - bit 1 clear: overload only warns
// - overload always warns controller and output
// - bits 2-7 select 8..25 A, default 5
// - several selects: smallest limit wins
package scd_pkg;

	localparam int SW_W = 8;
	localparam int LIM_W = 5;
	localparam logic [7:0] ADDR_AUTO = 8'h00;

	// current limits in amperes
	localparam logic [4:0] LIM_DEFAULT_A = 5'h05;
	localparam logic [4:0] LIM_B2_A = 5'h08;
	localparam logic [4:0] LIM_B3_A = 5'h0A;
	localparam logic [4:0] LIM_B4_A = 5'h0C;
	localparam logic [4:0] LIM_B5_A = 5'h10;
	localparam logic [4:0] LIM_B6_A = 5'h14;
	localparam logic [4:0] LIM_B7_A = 5'h19;

	// config switch field positions (bit 1 of the switch is index 0)
	localparam int CFG_TORQUE_BIT = 0;
	localparam int CFG_B2 = 1;
	localparam int CFG_B3 = 2;
	localparam int CFG_B4 = 3;
	localparam int CFG_B5 = 4;
	localparam int CFG_B6 = 5;
	localparam int CFG_B7 = 6;

	// slave states, gray coded along init -> preop -> op
	typedef enum logic [1:0] {
		SCD_INIT = 2'h0,
		SCD_PREOP = 2'h1,
		SCD_OP = 2'h3
	} scd_state_e;

	// master register offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_POSITION = 12'h004;
	localparam logic [11:0] REG_STORED = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00C;
	localparam logic [11:0] REG_ERROR = 12'h010;
	localparam logic [11:0] REG_INT_STATUS = 12'h014;
	localparam logic [11:0] REG_INT_CLEAR = 12'h018;
	localparam logic [11:0] REG_INT_ENABLE = 12'h01C;

	// field positions
	localparam int CTRL_AUTO = 0;
	localparam int CTRL_OPREQ = 1;
	localparam int STORED_EN = 8;
	localparam int ST_VALID = 8;
	localparam int ST_STATE_LO = 9;
	localparam int ST_WARN = 11;
	localparam int ST_CFGERR = 12;
	localparam int ERR_INFO_LO = 16;
	localparam int INT_W = 3;
	localparam int INT_WARN = 0;
	localparam int INT_CFGERR = 1;
	localparam int INT_ADDR = 2;

	// configuration error report
	localparam logic [15:0] CFG_ERR_CODE = 16'h0AA7;
	localparam logic [7:0] CFG_ERR_INFO = 8'h02;

endpackage

// ==== include/scd_link_if.sv ====
// Purpose: link between the switch decoder slave and the fieldbus master end
// Assumes: both ends clocked by sys_clk
// Notes: all signals are levels except assign_valid, a one-cycle pulse
`timescale 1ns/1ps
interface scd_link_if;
	logic assign_valid;
	logic [7:0] assign_addr;
	logic config_error;
	logic op_req;
	logic [7:0] node_addr;
	logic addr_valid;
	logic [1:0] slave_state;
	logic service_ready;
	logic overload_warn;

	modport device (
		input assign_valid, assign_addr, config_error, op_req,
		output node_addr, addr_valid, slave_state, service_ready, overload_warn
	);
	modport master (
		output assign_valid, assign_addr, config_error, op_req,
		input node_addr, addr_valid, slave_state, service_ready, overload_warn
	);
endinterface

// ==== hdl/scd_master.sv ====
// Purpose: fieldbus master end: assigns addresses, checks stored configuration
// Assumes: APB slave clocked by sys_clk, zero wait states
// Notes: one slave on the link; position register stands for its chain position
`timescale 1ns/1ps
module scd_master (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// fieldbus link
	scd_link_if.master link
);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic acc;
	logic wr;
	logic mapped;
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign pready = 1'b1;
	always_comb begin
		case (paddr)
			scd_pkg::REG_CTRL, scd_pkg::REG_POSITION, scd_pkg::REG_STORED,
			scd_pkg::REG_STATUS, scd_pkg::REG_ERROR, scd_pkg::REG_INT_STATUS,
			scd_pkg::REG_INT_CLEAR, scd_pkg::REG_INT_ENABLE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = acc && !mapped;

	// ----------------------------------------------------------------
	// registers and link control
	// ----------------------------------------------------------------
	logic [1:0] ctrl;
	logic [7:0] position;
	logic [8:0] stored;
	logic pending;
	logic assign_valid;
	logic cfg_err;
	logic [2:0] int_status;
	logic [2:0] int_enable;
	logic warn_d;
	logic valid_d;
	logic [31:0] rdata;
	logic [1:0] next_ctrl;
	logic [7:0] next_position;
	logic [8:0] next_stored;
	logic next_pending;
	logic next_assign_valid;
	logic next_cfg_err;
	logic [2:0] next_int_status;
	logic [2:0] next_int_enable;
	logic [2:0] events;
	logic [2:0] clr;
	logic [31:0] next_rdata;

	always_comb begin
		next_ctrl = ctrl;
		next_position = position;
		next_stored = stored;
		next_pending = pending;
		next_int_enable = int_enable;
		next_cfg_err = cfg_err;
		clr = 3'h0;
		if (wr && paddr == scd_pkg::REG_CTRL) begin
			next_ctrl = pwdata[1:0];
			if (pwdata[scd_pkg::CTRL_AUTO] && !ctrl[scd_pkg::CTRL_AUTO]) begin
				next_pending = 1'b1;
			end
		end
		if (wr && paddr == scd_pkg::REG_POSITION) begin
			next_position = pwdata[7:0];
			next_pending = 1'b1;
			next_cfg_err = 1'b0;
		end
		if (wr && paddr == scd_pkg::REG_STORED) begin
			next_stored = pwdata[8:0];
			next_cfg_err = 1'b0;
		end
		if (wr && paddr == scd_pkg::REG_INT_CLEAR) begin
			clr = pwdata[2:0];
		end
		if (wr && paddr == scd_pkg::REG_INT_ENABLE) begin
			next_int_enable = pwdata[2:0];
		end
		// one assignment pulse carrying the chain position
		next_assign_valid = 1'b0;
		if (pending && ctrl[scd_pkg::CTRL_AUTO] && !assign_valid) begin
			next_assign_valid = position != scd_pkg::ADDR_AUTO;
			next_pending = 1'b0;
		end
		if (link.addr_valid && stored[scd_pkg::STORED_EN] && link.node_addr != stored[7:0]) begin
			next_cfg_err = 1'b1;
		end
		events = 3'h0;
		events[scd_pkg::INT_WARN] = link.overload_warn && !warn_d;
		events[scd_pkg::INT_CFGERR] = next_cfg_err && !cfg_err;
		events[scd_pkg::INT_ADDR] = link.addr_valid && !valid_d;
		// an event in the clearing cycle stays set
		next_int_status = (int_status & ~clr) | events;
		next_rdata = 32'h0000_0000;
		case (paddr)
			scd_pkg::REG_CTRL: next_rdata[1:0] = ctrl;
			scd_pkg::REG_POSITION: next_rdata[7:0] = position;
			scd_pkg::REG_STORED: next_rdata[8:0] = stored;
			scd_pkg::REG_STATUS: begin
				next_rdata[7:0] = link.node_addr;
				next_rdata[scd_pkg::ST_VALID] = link.addr_valid;
				next_rdata[scd_pkg::ST_STATE_LO +: 2] = link.slave_state;
				next_rdata[scd_pkg::ST_WARN] = link.overload_warn;
				next_rdata[scd_pkg::ST_CFGERR] = cfg_err;
			end
			scd_pkg::REG_ERROR: begin
				if (cfg_err) begin
					next_rdata[15:0] = scd_pkg::CFG_ERR_CODE;
					next_rdata[scd_pkg::ERR_INFO_LO +: 8] = scd_pkg::CFG_ERR_INFO;
				end
			end
			scd_pkg::REG_INT_STATUS: next_rdata[2:0] = int_status;
			scd_pkg::REG_INT_ENABLE: next_rdata[2:0] = int_enable;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl <= 2'h0;
			position <= 8'h00;
			stored <= 9'h000;
			pending <= 1'b0;
			assign_valid <= 1'b0;
			cfg_err <= 1'b0;
			int_status <= 3'h0;
			int_enable <= 3'h0;
			warn_d <= 1'b0;
			valid_d <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			position <= next_position;
			stored <= next_stored;
			pending <= next_pending;
			assign_valid <= next_assign_valid;
			cfg_err <= next_cfg_err;
			int_status <= next_int_status;
			int_enable <= next_int_enable;
			warn_d <= link.overload_warn;
			valid_d <= link.addr_valid;
			rdata <= next_rdata;
		end
	end

	// read data registered in the setup cycle, valid in the access cycle
	assign prdata = rdata;
	assign irq = |(int_status & int_enable);
	assign link.assign_valid = assign_valid;
	assign link.assign_addr = position;
	assign link.config_error = cfg_err;
	// no operational request to a slave without an address
	assign link.op_req = ctrl[scd_pkg::CTRL_OPREQ] && link.addr_valid && !cfg_err;

endmodule

// ==== dv/scd_chk.sv ====
// Purpose: link checks between the switch decoder end and the master end
// Assumes: one clock domain, asynchronous active-low reset
// Notes: sees only the link signals
`timescale 1ns/1ps
module scd_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// master to device
	input wire logic assign_valid,
	input wire logic [7:0] assign_addr,
	input wire logic config_error,
	input wire logic op_req,
	// device to master
	input wire logic [7:0] node_addr,
	input wire logic addr_valid,
	input wire logic [1:0] slave_state,
	input wire logic service_ready,
	input wire logic overload_warn
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// addressing
	// ----------------------------------------
	chk_auto_take:
		assert property (assign_valid && assign_addr != 8'h00 && !addr_valid
			|=> addr_valid && node_addr == $past(assign_addr))
		else $error("assigned address not taken");
	chk_addr_held:
		assert property (addr_valid && !assign_valid |=> $stable(node_addr))
		else $error("node address changed without assignment");
	chk_op_gate:
		assert property (op_req |-> addr_valid && !config_error)
		else $error("operation requested without valid address");

	// ----------------------------------------
	// slave state
	// ----------------------------------------
	chk_op_addr:
		assert property (slave_state == 2'h3 |-> addr_valid)
		else $error("operational without address");
	chk_preop_entry:
		assert property ($rose(addr_valid) |=> slave_state == 2'h1)
		else $error("no pre-operational after address");
	chk_op_entry:
		assert property (slave_state == 2'h1 && op_req && !config_error
			|=> slave_state == 2'h3)
		else $error("no operational after request");
	chk_cfg_preop:
		assert property (config_error |=> slave_state != 2'h3)
		else $error("operational despite configuration error");
	chk_service_open:
		assert property (slave_state == 2'h1 |-> service_ready)
		else $error("service channel closed in pre-operational");
endmodule

// ==== dv/test_switch_config_decoder.sv ====
// Purpose: self-checking bench for both ends of the switch decoder link
// Assumes: sys_clk 100 MHz; resetn stands for a power cycle
// Notes: corner config switch settings first, then random ones from a fixed seed; address switch random except 8'hFF once
`timescale 1ns/1ps
module test_switch_config_decoder;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] addr_sw = 8'h00;
	logic [7:0] cfg_sw = 8'h00;
	logic ovl = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, irq, torque, warn, perr;
	logic [4:0] lim;
	logic [31:0] rd;
	logic [7:0] a, c;
	logic [7:0] corner [7] = '{8'h00, 8'h80, 8'h81, 8'hFE, 8'h7F, 8'h41, 8'h05};
	int errors = 0;
	int compares = 0;
	int seed = 32'h95e1;

	scd_link_if link();
	scd_device u_scd_device (.sys_clk(sys_clk), .resetn(resetn), .node_address_switch(addr_sw),
		.overload_config_switch(cfg_sw), .overload_detected(ovl), .torque_off_signal(torque),
		.overload_warning_output(warn), .current_limit_a(lim), .link(link));
	scd_master u_scd_master (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .link(link));
	scd_chk u_scd_chk (.sys_clk(sys_clk), .resetn(resetn), .assign_valid(link.assign_valid),
		.assign_addr(link.assign_addr), .config_error(link.config_error), .op_req(link.op_req),
		.node_addr(link.node_addr), .addr_valid(link.addr_valid),
		.slave_state(link.slave_state), .service_ready(link.service_ready),
		.overload_warn(link.overload_warn));

	always #5 sys_clk = ~sys_clk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [4:0] exp_lim(input logic [7:0] cfg);
		logic [4:0] t [6] = '{5'h08, 5'h0A, 5'h0C, 5'h10, 5'h14, 5'h19};
		for (int i = 1; i < 7; i++) begin
			if (cfg[i]) return t[i-1];
		end
		return 5'h05;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic power(input logic [7:0] av, input logic [7:0] cv);
		resetn <= 1'b0;
		addr_sw <= av;
		cfg_sw <= cv;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask

	// apb transfer, one idle cycle after it
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rchk(input logic [11:0] ad, input logic [31:0] exp);
		apb(1'b0, ad, 32'h00000000);
		chk(rd, exp);
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 14; i++) begin
			a = 8'($random(seed));
			c = (i < 7) ? corner[i] : 8'($random(seed));
			if (i == 1) a = 8'hFF;
			if (a == 8'h00) a = 8'h01;
			power(a, c);
			chk({23'h0, link.addr_valid, link.node_addr}, {23'h0, 1'b1, a});
			chk({27'h0, lim}, {27'h0, exp_lim(c)});
			addr_sw <= ~a;
			cfg_sw <= ~c;
			ovl <= 1'b1;
			repeat (2) @(posedge sys_clk);
			chk({29'h0, torque, warn, link.overload_warn}, {29'h0, c[0], 2'b11});
			chk({24'h0, link.node_addr}, {24'h0, a});
			chk({27'h0, lim}, {27'h0, exp_lim(c)});
			ovl <= 1'b0;
			repeat (2) @(posedge sys_clk);
			chk({30'h0, torque, warn}, 32'h0);
		end
		$display("switch decode tests done");
		power(8'h00, 8'h05);
		chk({31'h0, link.addr_valid}, 32'h0);
		apb(1'b1, scd_pkg::REG_INT_ENABLE, 32'h00000007);
		apb(1'b1, scd_pkg::REG_POSITION, 32'h00000003);
		apb(1'b1, scd_pkg::REG_CTRL, 32'h00000001);
		repeat (6) @(posedge sys_clk);
		rchk(scd_pkg::REG_STATUS, 32'h00000303);
		chk({31'h0, irq}, 32'h1);
		rchk(scd_pkg::REG_INT_STATUS, 32'h00000004);
		apb(1'b1, scd_pkg::REG_INT_CLEAR, 32'h00000007);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, scd_pkg::REG_CTRL, 32'h00000003);
		repeat (4) @(posedge sys_clk);
		rchk(scd_pkg::REG_STATUS, 32'h00000703);
		apb(1'b1, scd_pkg::REG_STORED, 32'h00000105);
		repeat (4) @(posedge sys_clk);
		rchk(scd_pkg::REG_ERROR, 32'h00020AA7);
		rchk(scd_pkg::REG_STATUS, 32'h00001303);
		chk({31'h0, link.service_ready}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, scd_pkg::REG_INT_ENABLE, 32'h00000000);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, scd_pkg::REG_POSITION, 32'h00000005);
		repeat (6) @(posedge sys_clk);
		apb(1'b1, scd_pkg::REG_STORED, 32'h00000105);
		repeat (6) @(posedge sys_clk);
		rchk(scd_pkg::REG_STATUS, 32'h00000705);
		rchk(scd_pkg::REG_ERROR, 32'h00000000);
		rchk(scd_pkg::REG_POSITION, 32'h00000005);
		rchk(scd_pkg::REG_STORED, 32'h00000105);
		ovl <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rchk(scd_pkg::REG_STATUS, 32'h00000F05);
		chk({30'h0, torque, warn}, 32'h00000003);
		rchk(scd_pkg::REG_INT_STATUS, 32'h00000003);
		apb(1'b1, scd_pkg::REG_INT_ENABLE, 32'h00000001);
		chk({31'h0, irq}, 32'h1);
		rchk(scd_pkg::REG_INT_ENABLE, 32'h00000001);
		ovl <= 1'b0;
		apb(1'b0, 12'h020, 32'h00000000);
		chk({31'h0, perr}, 32'h1);
		chk(rd, 32'h00000000);
		$display("auto addressing tests done");
		finish_test;
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		$display("[ERR] %0t watchdog expired", $time);
		finish_test;
	end
endmodule
